/* File: shared/retop_pkg.sv */
// constants and carrier types for the return and option-load decoder
package retop_pkg;
  localparam int          INSTR_W          = 14;
  localparam int          PC_W             = 13;
  localparam int          CLK_MHZ          = 40;
  localparam int          CYCLE_NS         = 100;                    // one instruction cycle
  localparam int          QUARTER_CLKS     = (CYCLE_NS * CLK_MHZ) / 4000;
  localparam logic [1:0]  Q_LAST           = 2'(QUARTER_CLKS * 4 - 1);
  localparam int          RET_CYCLES       = 2;
  localparam int          IRQ_EN_BIT       = 7;                      // enable bit of irq control
  localparam logic [13:0] OP_RETFI         = 14'h0009;
  localparam logic [13:0] OP_RETURN        = 14'h0008;
  localparam logic [13:0] OP_OPTLOAD       = 14'h0062;
  localparam logic [5:0]  OP_RETLIT_HI     = 6'h34;                  // 11 01xx
  localparam logic [3:0]  OP_RETLIT_MASKHI = 4'hD;
  localparam logic [7:0]  OPTION_RESET     = 8'hFF;
  localparam logic [7:0]  IRQCTL_RESET     = 8'h00;

  typedef enum logic [2:0] {
    DEC_NONE,
    DEC_RETFI,
    DEC_RETURN,
    DEC_RETLIT,
    DEC_OPTLOAD
  } dec_kind_t;

  // software access to the option or irq control register by ordinary addressing
  typedef struct packed {
    logic       wr;
    logic [7:0] data;
  } reg_wr_t;
endpackage

/* File: verilog/retop_reg8.sv */
// eight-bit register with reset value and two write ports
`timescale 1ns/100ps
module retop_reg8 #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  // clock and reset
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  // write ports, port a has priority
  input  wire logic       wr_a_in,
  input  wire logic [7:0] data_a_in,
  input  wire logic       wr_b_in,
  input  wire logic [7:0] data_b_in,
  // stored value
  output logic      [7:0] q_out
);
  // store the winning write
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      q_out <= RESET_VALUE;
    end else if (wr_a_in) begin
      q_out <= data_a_in;
    end else if (wr_b_in) begin
      q_out <= data_b_in;
    end
  end
endmodule // retop_reg8

/* File: verilog/return_and_option_ops.sv */
// decoder and executor for return, literal-return, interrupt-return and option-load ops
// Operation
// - interrupt return pops stack into program counter
// - interrupt return sets global enable, flags untouched
// - interrupt return takes two cycles, second idle
// - option-load copies accumulator to option register
// - option register also reachable by ordinary addressing
// - literal return loads accumulator, pops, two cycles
`timescale 1ns/100ps
module return_and_option_ops (
  // clock and reset
  input  wire logic                           clk_in,
  input  wire logic                           reset_n_in,
  // instruction fetch
  input  wire logic                           instr_valid_in,
  input  wire logic [retop_pkg::INSTR_W-1:0]  instr_in,
  // core state
  input  wire logic [7:0]                     accum_in,
  input  wire logic [retop_pkg::PC_W-1:0]     stack_top_in,
  input  wire retop_pkg::reg_wr_t             option_wr_in,
  input  wire retop_pkg::reg_wr_t             irqctl_wr_in,
  // core updates
  output logic                                q_phase_end_out,
  output logic                                busy_out,
  output logic                                stack_pop_out,
  output logic                                pc_load_out,
  output logic [retop_pkg::PC_W-1:0]          pc_value_out,
  output logic                                accum_wr_out,
  output logic [7:0]                          accum_value_out,
  output logic [7:0]                          option_out,
  output logic [7:0]                          interrupt_control_reg_out,
  output logic                                global_irq_enable_out
);

  // decode one instruction word; used for issue and for checking
  function automatic retop_pkg::dec_kind_t decode(input logic [13:0] w);
    if (w == retop_pkg::OP_RETFI)
      return retop_pkg::DEC_RETFI;
    else if (w == retop_pkg::OP_RETURN)
      return retop_pkg::DEC_RETURN;
    else if (w == retop_pkg::OP_OPTLOAD)
      return retop_pkg::DEC_OPTLOAD;
    else if (w[13:10] == retop_pkg::OP_RETLIT_MASKHI)
      return retop_pkg::DEC_RETLIT;
    else
      return retop_pkg::DEC_NONE;
  endfunction

  typedef enum logic [1:0] {ST_FETCH, ST_FLUSH} seq_t;

  logic [1:0]            q_phase;
  logic                  cycle_end;
  seq_t                  state;
  retop_pkg::dec_kind_t  kind;
  logic                  issue;
  logic                  opt_from_op;
  logic                  irq_set;
  logic [7:0]            irqctl_q;
  logic [7:0]            next_irqctl;

  assign kind      = decode(instr_in);
  assign cycle_end = (q_phase == retop_pkg::Q_LAST);
  assign issue     = cycle_end && instr_valid_in && (state == ST_FETCH);

  // four-phase divider of the core clock
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      q_phase         <= 2'h0;
      q_phase_end_out <= 1'b0;
    end else begin
      q_phase         <= cycle_end ? 2'h0 : q_phase + 2'h1;
      q_phase_end_out <= (q_phase == retop_pkg::Q_LAST - 2'h1);
    end
  end

  // two-cycle sequencing: returns spend one idle cycle after the pop
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state <= ST_FETCH;
    end else if (cycle_end) begin
      case (state)
        ST_FETCH: begin
          if (instr_valid_in && kind inside {retop_pkg::DEC_RETFI, retop_pkg::DEC_RETURN,
                                             retop_pkg::DEC_RETLIT}) begin
            state <= ST_FLUSH;
          end
        end
        ST_FLUSH: state <= ST_FETCH;
        default:  state <= ST_FETCH;
      endcase
    end
  end

  // stack pop and program counter reload, one pulse per return
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      stack_pop_out <= 1'b0;
      pc_load_out   <= 1'b0;
      pc_value_out  <= '0;
      busy_out      <= 1'b0;
    end else begin
      stack_pop_out <= issue && kind inside {retop_pkg::DEC_RETFI, retop_pkg::DEC_RETURN,
                                             retop_pkg::DEC_RETLIT};
      pc_load_out   <= issue && kind inside {retop_pkg::DEC_RETFI, retop_pkg::DEC_RETURN,
                                             retop_pkg::DEC_RETLIT};
      if (issue) begin
        pc_value_out <= stack_top_in;
      end
      // busy covers the four clocks of the idle cycle only, dropping at its end
      busy_out      <= (state == ST_FLUSH && !cycle_end) ||
                       (issue && kind != retop_pkg::DEC_NONE &&
                        kind != retop_pkg::DEC_OPTLOAD);
    end
  end

  // accumulator write for literal return; plain returns leave it alone
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      accum_wr_out    <= 1'b0;
      accum_value_out <= 8'h00;
    end else begin
      accum_wr_out <= issue && kind == retop_pkg::DEC_RETLIT;
      if (issue && kind == retop_pkg::DEC_RETLIT) begin
        accum_value_out <= instr_in[7:0];
      end
    end
  end

  // option register: op load or direct addressed write
  assign opt_from_op = issue && kind == retop_pkg::DEC_OPTLOAD;

  retop_reg8 #(
    .RESET_VALUE (retop_pkg::OPTION_RESET)
  ) option_reg (
    .clk_in     (clk_in),
    .reset_n_in (reset_n_in),
    .wr_a_in    (opt_from_op),
    .data_a_in  (accum_in),
    .wr_b_in    (option_wr_in.wr),
    .data_b_in  (option_wr_in.data),
    .q_out      (option_out)
  );

  // interrupt control: hardware enable set wins over software write
  assign irq_set = issue && kind == retop_pkg::DEC_RETFI;
  always_comb begin
    next_irqctl = irqctl_q;
    if (irqctl_wr_in.wr) begin
      next_irqctl = irqctl_wr_in.data;
    end
    if (irq_set) begin
      next_irqctl[retop_pkg::IRQ_EN_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      irqctl_q <= retop_pkg::IRQCTL_RESET;
    end else begin
      irqctl_q <= next_irqctl;
    end
  end

  assign interrupt_control_reg_out = irqctl_q;
  assign global_irq_enable_out     = irqctl_q[retop_pkg::IRQ_EN_BIT];

  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);

  pop_loads_pc_a: assert property (issue && kind == retop_pkg::DEC_RETFI |=>
      stack_pop_out && pc_load_out && pc_value_out == $past(stack_top_in))
    else $error("interrupt return did not reload counter");
  irq_enable_set_a: assert property (irq_set |=> global_irq_enable_out)
    else $error("global enable not set");
  retfi_two_cycles_a: assert property (irq_set |=> busy_out [*4] ##1 !stack_pop_out)
    else $error("interrupt return timing wrong");
  option_load_a: assert property (opt_from_op && !option_wr_in.wr |=>
      option_out == $past(accum_in))
    else $error("option load lost accumulator");
  option_direct_a: assert property (option_wr_in.wr && !opt_from_op |=>
      option_out == $past(option_wr_in.data))
    else $error("direct option write lost");
  retlit_accum_a: assert property (issue && kind == retop_pkg::DEC_RETLIT |=>
      accum_wr_out && stack_pop_out && accum_value_out == $past(instr_in[7:0]))
    else $error("literal return wrong");
  return_plain_a: assert property (issue && kind == retop_pkg::DEC_RETURN |=>
      stack_pop_out && !accum_wr_out ##4 !stack_pop_out)
    else $error("plain return wrong");
  no_issue_flush_a: assert property (busy_out && q_phase_end_out |=>
      !stack_pop_out && !accum_wr_out && !busy_out)
    else $error("issue during idle cycle");

  retfi_c:  cover property (irq_set);
  retlit_c: cover property (issue && kind == retop_pkg::DEC_RETLIT);
  optld_c:  cover property (opt_from_op);
  return_c: cover property (issue && kind == retop_pkg::DEC_RETURN);
endmodule // return_and_option_ops

/* File: verif/return_and_option_ops_bench.sv */
// table-driven bench for the return and option-load decoder
`timescale 1ns/100ps
module return_and_option_ops_bench;
  typedef struct packed {
    logic [13:0] ins;
    logic [7:0]  acc;
    logic [12:0] top;
    logic        pop;
    logic        awr;
    logic [7:0]  av;
    logic [7:0]  opt;
  } row_t;

  logic               clk_in;
  logic               reset_n_in;
  logic               valid;
  logic [13:0]        instr;
  logic [7:0]         accum;
  logic [12:0]        stack_top;
  retop_pkg::reg_wr_t option_wr;
  retop_pkg::reg_wr_t irqctl_wr;
  logic               q_end;
  logic               busy;
  logic               pop;
  logic               pc_load;
  logic [12:0]        pc_value;
  logic               accum_wr;
  logic [7:0]         accum_value;
  logic [7:0]         option;
  logic [7:0]         irqctl;
  logic               global_irq_enable;
  int                 error_cnt = 0;
  int                 checked = 0;
  int                 cycles = 0;
  row_t               rows [7];

  return_and_option_ops i_return_and_option_ops (
    .clk_in(clk_in), .reset_n_in(reset_n_in), .instr_valid_in(valid), .instr_in(instr),
    .accum_in(accum), .stack_top_in(stack_top), .option_wr_in(option_wr),
    .irqctl_wr_in(irqctl_wr), .q_phase_end_out(q_end), .busy_out(busy),
    .stack_pop_out(pop), .pc_load_out(pc_load), .pc_value_out(pc_value),
    .accum_wr_out(accum_wr), .accum_value_out(accum_value), .option_out(option),
    .interrupt_control_reg_out(irqctl), .global_irq_enable_out(global_irq_enable));

  // free-running core clock
  initial begin
    clk_in = 1'h0;
    forever #12.5 clk_in = ~clk_in;
  end

  // cut a hang short
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 2000) begin
      error_cnt++;
      summarize();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // reset for n clocks, then look at the reset values
  task automatic do_reset(input int n);
    reset_n_in = 1'h0;
    repeat (n) @(negedge clk_in);
    reset_n_in = 1'h1;
    check(option, 16'h00FF);
    check(irqctl, 16'h0000);
    check(global_irq_enable, 16'h0000);
    check(busy, 16'h0000);
  endtask

  // present a word in the last clock of a cycle, return half a clock after it is taken
  task automatic issue(input logic [13:0] ins, input logic [7:0] acc, input logic [12:0] top);
    while (q_end !== 1'h1) @(negedge clk_in);
    instr = ins;
    accum = acc;
    stack_top = top;
    valid = 1'h1;
    @(negedge clk_in);
  endtask

  initial begin
    {valid, instr, accum, stack_top, option_wr, irqctl_wr} = '0;
    reset_n_in = 1'h0;
    rows[0] = {14'h0009, 8'h11, 13'h0123, 1'h1, 1'h0, 8'h00, 8'hFF};
    rows[1] = {14'h0008, 8'h22, 13'h1ABC, 1'h1, 1'h0, 8'h00, 8'hFF};
    rows[2] = {14'h3456, 8'h33, 13'h0001, 1'h1, 1'h1, 8'h56, 8'hFF};
    rows[3] = {14'h37FF, 8'h44, 13'h1FFF, 1'h1, 1'h1, 8'hFF, 8'hFF};
    rows[4] = {14'h0062, 8'hA5, 13'h0000, 1'h0, 1'h0, 8'h00, 8'hA5};
    rows[5] = {14'h0063, 8'h5A, 13'h0000, 1'h0, 1'h0, 8'h00, 8'hA5};
    rows[6] = {14'h0062, 8'h00, 13'h0000, 1'h0, 1'h0, 8'h00, 8'h00};
    @(negedge clk_in);
    do_reset(12);
    // software preset of irq control with enable clear
    irqctl_wr = '{1'h1, 8'h15};
    @(negedge clk_in);
    irqctl_wr = '0;
    check(irqctl, 16'h0015);
    foreach (rows[i]) begin
      issue(rows[i].ins, rows[i].acc, rows[i].top);
      check(pop, rows[i].pop);
      check(pc_load, rows[i].pop);
      if (rows[i].pop) check(pc_value, rows[i].top);
      check(accum_wr, rows[i].awr);
      if (rows[i].awr) check(accum_value, rows[i].av);
      check(option, rows[i].opt);
      check(global_irq_enable, 16'h0001);
      check(busy, rows[i].pop);
      valid = 1'h0;
      while (busy === 1'h1) @(negedge clk_in);
    end
    check(irqctl, 16'h0095);
    // a word held into the idle cycle is ignored, then taken
    issue(14'h0008, 8'h00, 13'h0400);
    instr = 14'h0062;
    accum = 8'h3C;
    repeat (3) begin
      @(negedge clk_in);
      check(busy, 16'h0001);
    end
    @(negedge clk_in);
    check(option, 16'h0000);
    check(busy, 16'h0000);
    check(pop, 16'h0000);
    repeat (4) @(negedge clk_in);
    check(option, 16'h003C);
    valid = 1'h0;
    // direct write of the option register by ordinary addressing
    option_wr = '{1'h1, 8'hC3};
    @(negedge clk_in);
    option_wr = '0;
    check(option, 16'h00C3);
    do_reset(2);
    // phase restarts after reset: first cycle end in the third clock after release
    repeat (2) begin
      @(negedge clk_in);
      check(q_end, 16'h0000);
    end
    @(negedge clk_in);
    check(q_end, 16'h0001);
    summarize();
  end
endmodule // return_and_option_ops_bench
